//--- hlf_host_end.sv
module hlf_host_end (
  input wire logic mclk,
  input wire logic rst_n,
  hlf_link_if.host link,
  input wire logic sendStart,
  input wire logic nopBurst,
  input wire logic withData,
  input wire logic prioBit,
  input wire logic trace,
  input wire logic destFlag,
  input wire logic [7:0] msgType,
  input wire logic [3:0] subType,
  input wire logic [15:0] srcName,
  input wire logic [15:0] dstName,
  input wire logic [11:0] msgId,
  input wire logic payloadValid,
  input wire logic [15:0] payloadWord,
  input wire logic payloadLast,
  output logic payloadReady,
  output logic busy
);
  // Sender states.
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_LEAD = 3'b010,
    H_DATA = 3'b100
  } hlf_host_state_t;

  hlf_host_state_t state;
  // Leader words held for the whole send.
  logic [5:0][15:0] lead;
  // Index of the leader word on the link.
  logic [2:0] idx;
  // Further no-operation leaders still to send.
  logic [1:0] nopLeft;
  // Message carries payload after its leader.
  logic hasData;

  // Builds a leader with every unused and reserved bit at zero.
  function automatic logic [5:0][15:0] build(
    input logic p, input logic t, input logic d, input logic [7:0] ty,
    input logic [3:0] st, input logic [15:0] s, input logic [15:0] ds,
    input logic [11:0] id);
    logic [5:0][15:0] w;
    w = '0;
    w[0] = {4'h0, hlf_pkg::STYLE_FLAG_H2N, p, 7'h00};
    w[1] = {4'h0, t, d, 2'h0, ty};
    w[2] = s;
    w[3] = ds;
    w[4] = {id, st};
    w[5] = 16'h0000;
    return w;
  endfunction

  // Handshake outputs follow the state.
  always_comb begin
    link.valid = 1'b0;
    link.word = 16'h0000;
    link.last = 1'b0;
    payloadReady = 1'b0;
    case (state)
      H_LEAD: begin
        link.valid = 1'b1;
        link.word = lead[idx];
        link.last = (idx == hlf_pkg::LAST_WORD_IDX) && !hasData;
      end
      H_DATA: begin
        link.valid = payloadValid;
        link.word = payloadWord;
        link.last = payloadLast;
        payloadReady = link.ready;
      end
      default: begin
        link.valid = 1'b0;
      end
    endcase
  end

  assign busy = (state != H_IDLE);

  // Sequencing of leaders, bursts and payload.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= H_IDLE;
      idx <= 3'h0;
      nopLeft <= 2'h0;
      hasData <= 1'b0;
      lead <= '0;
    end else begin
      case (state)
        H_IDLE: begin
          idx <= 3'h0;
          if (nopBurst) begin
            // Three back-to-back no-operation leaders.
            lead <= build(1'b0, 1'b0, 1'b0, hlf_pkg::TYPE_NO_OP, 4'h0,
                          16'h0000, 16'h0000, 12'h000);
            nopLeft <= hlf_pkg::NOP_BURST - 2'h1;
            hasData <= 1'b0;
            state <= H_LEAD;
          end else if (sendStart) begin
            lead <= build(prioBit, trace, destFlag, msgType, subType,
                          srcName, dstName, msgId);
            nopLeft <= 2'h0;
            hasData <= withData;
            state <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (link.ready) begin
            if (idx == hlf_pkg::LAST_WORD_IDX) begin
              idx <= 3'h0;
              if (hasData) begin
                state <= H_DATA;
              end else if (nopLeft != 2'h0) begin
                nopLeft <= nopLeft - 2'h1;
              end else begin
                state <= H_IDLE;
              end
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        H_DATA: begin
          if (payloadValid && link.ready && payloadLast) begin
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule : hlf_host_end

//--- hlf_link_if.sv
interface hlf_link_if;
  // Word carried from host to node.
  logic [15:0] word;
  // Host offers a word.
  logic valid;
  // Node takes the word in this cycle.
  logic ready;
  // Word is the final word of a message.
  logic last;
  modport host (output word, output valid, output last, input ready);
  modport node (input word, input valid, input last, output ready);
endinterface : hlf_link_if

//--- hlf_link_props.sv
module hlf_link_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] word,
  input wire logic valid,
  input wire logic ready,
  input wire logic last
);
  timeunit 1ns;
  timeprecision 1ps;
  // Place of the offered word in its message; 6 means payload.
  logic [2:0] wordCnt;
  // A word changes hands on this cycle.
  wire logic taken = valid && ready;

  // Counts taken words and restarts after the final one.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wordCnt <= 3'h0;
    end else if (taken) begin
      wordCnt <= last ? 3'h0 : ((wordCnt == 3'h6) ? 3'h6 : wordCnt + 3'h1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_top_zero: assert property (
    valid && wordCnt == 3'h0 |-> word[15:12] == 4'h0)
    else $error("leader top bits not zero");
  a_style_flag: assert property (
    valid && wordCnt == 3'h0 |-> word[11:8] == hlf_pkg::STYLE_FLAG_H2N)
    else $error("leader style flag wrong");
  a_handling_zero: assert property (
    valid && wordCnt == 3'h0 |-> word[6:0] == 7'h00)
    else $error("handling bits not zero");
  a_word1_zero: assert property (
    valid && wordCnt == 3'h1 |-> word[15:12] == 4'h0 && word[9:8] == 2'h0)
    else $error("second word zero bits set");
  a_tail_zero: assert property (
    valid && wordCnt == 3'h5 |-> word == 16'h0000)
    else $error("final leader word not zero");
  a_leader_len: assert property (
    valid && last |-> wordCnt >= 3'h5)
    else $error("message ended inside leader");
  a_hold_word: assert property (
    valid && !ready |=> valid && $stable(word) && $stable(last))
    else $error("word dropped before taken");
  a_eval_stall: assert property (
    taken && wordCnt == 3'h5 |=> !ready)
    else $error("node ready after sixth word");
  a_ready_back: assert property (
    $fell(ready) |-> ##[1:12] ready)
    else $error("node stalled too long");
endmodule // hlf_link_props

//--- hlf_node_end.sv
// Behaviour
// - Host zeroes leader bits one to four.
// - Bits five to eight hold flag thirteen.
// - Handling bit nine set means priority.
// - Handling bits ten-sixteen, seventeen-twenty stay zero.
// - Bit twenty-one set marks message for tracing.
// - Bit twenty-two free; twenty-three, twenty-four zero.
// - Type in bits 25-32; subtype in 77-80.
// - Standard subtype gets full message control.
// - Uncontrolled subtype gets no message control.
// - Declaration payload: count, then name/value pairs.
// - Declaration reply gives each name's effectiveness.
// - Zero-entry declaration clears all effective names.
// - No-operation leader style sets later style.
// - Host sends no-operations in bursts of three.
// - Name server request translates destination name. Node only pulses nameServerReq.
// - Port list request returns this port's names.
// - Types one, two, eight keep base meanings.
// - Host fills source field; node never inserts.
// - Source name checked; failure blocks, reports error. Node checks regular-type messages only.
// - Source port address must match arrival port.
// - Non-effective destination name returns error.
// - Bits 65-76 message ID; 65-72 link field.
// - Host zeroes leader bits eighty-one to ninety-six.
module hlf_node_end #(
  parameter int NAME_SLOTS = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  hlf_link_if.node link,
  input wire logic [15:0] portAddr,
  input wire logic cfgWrite,
  input wire logic [$clog2(NAME_SLOTS)-1:0] cfgSlot,
  input wire logic [15:0] cfgName,
  input wire logic cfgAuth,
  output logic msgValid,
  output logic [7:0] msgType,
  output logic [3:0] msgSub,
  output logic [11:0] msgId,
  output logic [7:0] linkField,
  output logic [15:0] srcName,
  output logic [15:0] dstName,
  output logic prioBit,
  output logic trace,
  output logic destFlag,
  output logic controlled,
  output logic styleError,
  output logic leaderError,
  output logic srcError,
  output logic dstError,
  output logic nameServerReq,
  output logic logicalStyle,
  output logic replyStart,
  output logic [7:0] replyType,
  output logic [15:0] replyCount,
  output logic replyValid,
  output logic [15:0] replyName,
  output logic replyEff
);
  localparam int SW = $clog2(NAME_SLOTS);

  // Receiver states.
  typedef enum logic [6:0] {
    N_LEAD = 7'b0000001,
    N_EVAL = 7'b0000010,
    N_COUNT = 7'b0000100,
    N_NAME = 7'b0001000,
    N_VALUE = 7'b0010000,
    N_LIST = 7'b0100000,
    N_DRAIN = 7'b1000000
  } hlf_node_state_t;

  hlf_node_state_t state;
  // Leader words as received.
  logic [5:0][15:0] lw;
  // Index of the next leader word.
  logic [2:0] idx;
  // The leader's word was the message's final word.
  logic endSeen;
  // Entries of a declaration still to take.
  logic [15:0] entriesLeft;
  // Name of the declaration entry in progress.
  logic [15:0] entName;
  // Slot walked while listing this port's names.
  logic [SW-1:0] listSlot;
  // Name table of this port.
  logic [NAME_SLOTS-1:0][15:0] names;
  logic [NAME_SLOTS-1:0] authorized;
  logic [NAME_SLOTS-1:0] effective;
  logic take;

  // Slots whose authorized name equals n.
  function automatic logic [NAME_SLOTS-1:0] hits(input logic [15:0] n);
    logic [NAME_SLOTS-1:0] h;
    h = '0;
    for (int i = 0; i < NAME_SLOTS; i++) begin
      h[i] = authorized[i] && (names[i] == n);
    end
    return h;
  endfunction

  // Number of authorized names on this port.
  function automatic logic [15:0] authCount();
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < NAME_SLOTS; i++) begin
      c = c + {15'h0000, authorized[i]};
    end
    return c;
  endfunction

  // Node accepts words except while deciding or listing.
  assign link.ready = (state != N_EVAL) && (state != N_LIST);
  assign take = link.valid && link.ready;

  // Decoded leader fields, word layout bit one first.
  logic [3:0] fFlag;
  logic [7:0] fType;
  logic [3:0] fSub;
  logic fBadZero;
  logic srcOk;
  logic dstBad;
  logic [NAME_SLOTS-1:0] dstHit;
  // Authorized slots that hold the name of the declaration entry in progress.
  logic [NAME_SLOTS-1:0] entHit;
  always_comb begin
    fFlag = lw[0][hlf_pkg::W0_FLAG_HI:hlf_pkg::W0_FLAG_LO];
    fType = lw[1][hlf_pkg::W1_TYPE_HI:0];
    fSub = lw[4][hlf_pkg::W4_SUB_HI:0];
    fBadZero = (lw[0][hlf_pkg::W0_ZERO_HI:hlf_pkg::W0_ZERO_LO] != 4'h0)
      || (lw[0][hlf_pkg::W0_HRES_HI:0] != 7'h00)
      || (lw[1][hlf_pkg::W1_ZERO_HI:hlf_pkg::W1_ZERO_LO] != 4'h0)
      || (lw[1][hlf_pkg::W1_RES_HI:hlf_pkg::W1_RES_LO] != 2'h0)
      || (lw[5] != 16'h0000);
    // This port's address or an effective authorized name on this port passes.
    srcOk = (lw[2] == portAddr) || ((hits(lw[2]) & effective) != '0);
    dstHit = hits(lw[3]);
    entHit = hits(entName);
    dstBad = (dstHit != '0) && ((dstHit & effective) == '0);
  end

  // Receive sequencing.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= N_LEAD;
      idx <= 3'h0;
      lw <= '0;
      endSeen <= 1'b0;
      entriesLeft <= 16'h0000;
      entName <= 16'h0000;
      listSlot <= '0;
    end else begin
      case (state)
        N_LEAD: begin
          if (take) begin
            lw[idx] <= link.word;
            if (idx == hlf_pkg::LAST_WORD_IDX) begin
              idx <= 3'h0;
              endSeen <= link.last;
              state <= N_EVAL;
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        N_EVAL: begin
          listSlot <= '0;
          if (fFlag == hlf_pkg::STYLE_FLAG_H2N
              && fType == hlf_pkg::TYPE_PORT_LIST) begin
            state <= N_LIST;
          end else if (fFlag == hlf_pkg::STYLE_FLAG_H2N
                       && fType == hlf_pkg::TYPE_NAME_DECL && !endSeen) begin
            state <= N_COUNT;
          end else begin
            state <= endSeen ? N_LEAD : N_DRAIN;
          end
        end
        N_COUNT: begin
          if (take) begin
            entriesLeft <= link.word;
            if (link.last) begin
              state <= N_LEAD;
            end else begin
              state <= (link.word == 16'h0000) ? N_DRAIN : N_NAME;
            end
          end
        end
        N_NAME: begin
          if (take) begin
            entName <= link.word;
            state <= link.last ? N_LEAD : N_VALUE;
          end
        end
        N_VALUE: begin
          if (take) begin
            entriesLeft <= entriesLeft - 16'h0001;
            if (link.last) begin
              state <= N_LEAD;
            end else begin
              state <= (entriesLeft == 16'h0001) ? N_DRAIN : N_NAME;
            end
          end
        end
        N_LIST: begin
          listSlot <= listSlot + {{(SW-1){1'b0}}, 1'b1};
          if (listSlot == SW'(NAME_SLOTS - 1)) begin
            state <= endSeen ? N_LEAD : N_DRAIN;
          end
        end
        N_DRAIN: begin
          if (take && link.last) begin
            state <= N_LEAD;
          end
        end
        default: begin
          state <= N_LEAD;
        end
      endcase
    end
  end

  // Name table: configuration, declarations and the clear-all case.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      names <= '0;
      authorized <= '0;
      effective <= '0;
    end else begin
      if (state == N_COUNT && take && link.word == 16'h0000) begin
        effective <= '0;
      end else if (state == N_VALUE && take) begin
        for (int i = 0; i < NAME_SLOTS; i++) begin
          if (entHit[i] && link.word == hlf_pkg::DECL_ON) begin
            effective[i] <= 1'b1;
          end else if (entHit[i] && link.word == hlf_pkg::DECL_OFF) begin
            effective[i] <= 1'b0;
          end
        end
      end
      if (cfgWrite) begin
        // A reloaded slot starts non-effective.
        names[cfgSlot] <= cfgName;
        authorized[cfgSlot] <= cfgAuth;
        effective[cfgSlot] <= 1'b0;
      end
    end
  end

  // Leader verdicts, one-cycle pulses from the evaluation cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      msgValid <= 1'b0;
      msgType <= 8'h00;
      msgSub <= 4'h0;
      msgId <= 12'h000;
      linkField <= 8'h00;
      srcName <= 16'h0000;
      dstName <= 16'h0000;
      prioBit <= 1'b0;
      trace <= 1'b0;
      destFlag <= 1'b0;
      controlled <= 1'b0;
      styleError <= 1'b0;
      leaderError <= 1'b0;
      srcError <= 1'b0;
      dstError <= 1'b0;
      nameServerReq <= 1'b0;
    end else begin
      msgValid <= 1'b0;
      styleError <= 1'b0;
      leaderError <= 1'b0;
      srcError <= 1'b0;
      dstError <= 1'b0;
      nameServerReq <= 1'b0;
      if (state == N_EVAL) begin
        msgType <= fType;
        msgSub <= fSub;
        msgId <= lw[4][hlf_pkg::W4_ID_HI:hlf_pkg::W4_ID_LO];
        linkField <= lw[4][hlf_pkg::W4_ID_HI:hlf_pkg::W4_LINK_LO];
        srcName <= lw[2];
        dstName <= lw[3];
        prioBit <= lw[0][hlf_pkg::W0_PRIO];
        trace <= lw[1][hlf_pkg::W1_TRACE];
        destFlag <= lw[1][hlf_pkg::W1_DFLAG];
        controlled <= (fType == hlf_pkg::TYPE_REGULAR)
          && (fSub == hlf_pkg::SUB_STANDARD);
        styleError <= (fFlag != hlf_pkg::STYLE_FLAG_H2N);
        leaderError <= fBadZero;
        if (fFlag == hlf_pkg::STYLE_FLAG_H2N) begin
          if (fType == hlf_pkg::TYPE_REGULAR) begin
            srcError <= !srcOk;
            dstError <= srcOk && dstBad;
            msgValid <= srcOk && !dstBad;
          end else if (fType == hlf_pkg::TYPE_ERR_NO_ID
                       || fType == hlf_pkg::TYPE_GOING_DOWN
                       || fType == hlf_pkg::TYPE_ERR_WITH_ID) begin
            msgValid <= 1'b1;
          end
          nameServerReq <= (fType == hlf_pkg::TYPE_NAME_SERVER);
        end
      end
    end
  end

  // Leader style chosen by the host's latest no-operation leader.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      logicalStyle <= 1'b0;
    end else if (state == N_EVAL && fType == hlf_pkg::TYPE_NO_OP) begin
      logicalStyle <= (fFlag == hlf_pkg::STYLE_FLAG_H2N);
    end
  end

  // Reply stream for declaration and port list replies.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      replyStart <= 1'b0;
      replyType <= 8'h00;
      replyCount <= 16'h0000;
      replyValid <= 1'b0;
      replyName <= 16'h0000;
      replyEff <= 1'b0;
    end else begin
      replyStart <= 1'b0;
      replyValid <= 1'b0;
      if (state == N_COUNT && take) begin
        replyStart <= 1'b1;
        replyType <= hlf_pkg::TYPE_NAME_DECL;
        replyCount <= link.word;
      end else if (state == N_EVAL && fFlag == hlf_pkg::STYLE_FLAG_H2N
                   && fType == hlf_pkg::TYPE_PORT_LIST) begin
        replyStart <= 1'b1;
        replyType <= hlf_pkg::TYPE_PORT_LIST;
        replyCount <= authCount();
      end
      if (state == N_VALUE && take) begin
        // Effectiveness after this entry is applied.
        replyValid <= 1'b1;
        replyName <= entName;
        replyEff <= (hits(entName) != '0) && (link.word == hlf_pkg::DECL_ON
          || (link.word != hlf_pkg::DECL_OFF
              && (hits(entName) & effective) != '0));
      end else if (state == N_LIST && authorized[listSlot]) begin
        replyValid <= 1'b1;
        replyName <= names[listSlot];
        replyEff <= effective[listSlot];
      end
    end
  end
endmodule : hlf_node_end

//--- hlf_pkg.sv
package hlf_pkg;
  // Leader is six 16-bit words; bit 1 is the MSB of the first word.
  localparam int LEADER_WORDS = 6;
  localparam logic [2:0] LAST_WORD_IDX = 3'h5;
  // Style flag carried in bits 5-8 of a host-to-node leader.
  localparam logic [3:0] STYLE_FLAG_H2N = 4'hd;
  // Field positions inside word 0 (bits 1-16).
  localparam int W0_ZERO_HI = 15;
  localparam int W0_ZERO_LO = 12;
  localparam int W0_FLAG_HI = 11;
  localparam int W0_FLAG_LO = 8;
  localparam int W0_PRIO = 7;
  localparam int W0_HRES_HI = 6;
  // Field positions inside word 1 (bits 17-32).
  localparam int W1_ZERO_HI = 15;
  localparam int W1_ZERO_LO = 12;
  localparam int W1_TRACE = 11;
  localparam int W1_DFLAG = 10;
  localparam int W1_RES_HI = 9;
  localparam int W1_RES_LO = 8;
  localparam int W1_TYPE_HI = 7;
  // Field positions inside word 4 (bits 65-80).
  localparam int W4_ID_HI = 15;
  localparam int W4_ID_LO = 4;
  localparam int W4_LINK_LO = 8;
  localparam int W4_SUB_HI = 3;
  // Message types and regular-message subtypes.
  localparam logic [7:0] TYPE_REGULAR = 8'h00;
  localparam logic [7:0] TYPE_ERR_NO_ID = 8'h01;
  localparam logic [7:0] TYPE_GOING_DOWN = 8'h02;
  localparam logic [7:0] TYPE_NAME_DECL = 8'h03;
  localparam logic [7:0] TYPE_NO_OP = 8'h04;
  localparam logic [7:0] TYPE_ERR_WITH_ID = 8'h08;
  localparam logic [7:0] TYPE_NAME_SERVER = 8'h0b;
  localparam logic [7:0] TYPE_PORT_LIST = 8'h0c;
  localparam logic [3:0] SUB_STANDARD = 4'h0;
  localparam logic [3:0] SUB_UNCONTROLLED = 4'h3;
  // Name declaration entry values.
  localparam logic [15:0] DECL_ON = 16'h0001;
  localparam logic [15:0] DECL_OFF = 16'h0000;
  // Number of no-operation leaders in one burst.
  localparam logic [1:0] NOP_BURST = 2'h3;
endpackage : hlf_pkg

//--- host_leader_format_checker_tb_top.sv
module host_leader_format_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PORT = 16'h0a05;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  // Host user side.
  logic sendStart = 0, nopBurst = 0, withData = 0, prio = 0, trc = 0, dfl = 0;
  logic [7:0] ty = 0;
  logic [3:0] sub = 0;
  logic [15:0] src = 0, dst = 0, pW = 0;
  logic [11:0] id = 0;
  logic pV = 0, pL = 0, payloadReady, busy;
  // Node configuration and results.
  logic cfgWrite = 0, cfgAuth = 0;
  logic [1:0] cfgSlot = 0;
  logic [15:0] cfgName = 0;
  logic msgValid, rPrio, rTrace, rDflag, controlled, styleError, leaderError;
  logic srcError, dstError, nameServerReq, logicalStyle, replyStart;
  logic replyValid, replyEff;
  logic [7:0] msgType, linkField, replyType;
  logic [3:0] msgSub;
  logic [11:0] msgId;
  logic [15:0] srcName, dstName, replyCount, replyName;
  // Expected notes and counters.
  logic [73:0] qV[$], qM[$];
  logic [24:0] qR[$];
  logic [15:0] pl[$];
  int n_mismatch = 0, compares = 0, seed = 65557;
  bit ign = 1'b1;
  wire logic [73:0] actV = {msgValid, srcError, dstError, nameServerReq,
    leaderError, styleError, rPrio, rTrace, rDflag, controlled, msgType,
    msgSub, msgId, linkField, srcName, dstName};

  // Clock toggles every half period of 2 ns.
  always #2 mclk = ~mclk;

  hlf_link_if link_i();
  hlf_host_end hlf_host_end_i (.mclk(mclk), .rst_n(rst_n), .link(link_i),
    .sendStart(sendStart), .nopBurst(nopBurst), .withData(withData),
    .prioBit(prio), .trace(trc), .destFlag(dfl), .msgType(ty),
    .subType(sub), .srcName(src), .dstName(dst), .msgId(id),
    .payloadValid(pV), .payloadWord(pW), .payloadLast(pL),
    .payloadReady(payloadReady), .busy(busy));
  hlf_node_end #(.NAME_SLOTS(4)) hlf_node_end_i (.mclk(mclk), .rst_n(rst_n),
    .link(link_i), .portAddr(PORT), .cfgWrite(cfgWrite), .cfgSlot(cfgSlot),
    .cfgName(cfgName), .cfgAuth(cfgAuth), .msgValid(msgValid),
    .msgType(msgType), .msgSub(msgSub), .msgId(msgId),
    .linkField(linkField), .srcName(srcName), .dstName(dstName),
    .prioBit(rPrio), .trace(rTrace), .destFlag(rDflag),
    .controlled(controlled), .styleError(styleError),
    .leaderError(leaderError), .srcError(srcError), .dstError(dstError),
    .nameServerReq(nameServerReq), .logicalStyle(logicalStyle),
    .replyStart(replyStart), .replyType(replyType),
    .replyCount(replyCount), .replyValid(replyValid),
    .replyName(replyName), .replyEff(replyEff));
  hlf_link_props hlf_link_props_i (.mclk(mclk), .rst_n(rst_n),
    .word(link_i.word), .valid(link_i.valid), .ready(link_i.ready),
    .last(link_i.last));

  // Prints the counts and the verdict, then stops.
  task test_done;
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task fail(input logic [73:0] e, input logic [73:0] a);
    n_mismatch++;
    $display("FAIL t=%0t exp=%h act=%h", $time, e, a);
  endtask

  // A wait that ran out of its bound.
  task hang;
    n_mismatch++;
    test_done;
  endtask

  task cmpV(input logic [73:0] e, input logic [73:0] m, input logic [73:0] a);
    compares++;
    if ((a & m) !== (e & m)) fail(e, a);
  endtask

  task cmpR(input logic [24:0] e, input logic [24:0] a);
    compares++;
    if (a !== e) fail({49'h0, e}, {49'h0, a});
  endtask

  task cmpB(input logic e, input logic a);
    compares++;
    if (a !== e) fail({73'h0, e}, {73'h0, a});
  endtask

  task popR(input logic [24:0] a);
    if (qR.size() == 0) fail(74'h0, {49'h0, a});
    else cmpR(qR.pop_front(), a);
  endtask

  // Takes the oldest note off a queue whenever a result shows.
  always @(posedge mclk) begin
    if (rst_n && !ign && (msgValid | srcError | dstError | nameServerReq)) begin
      if (qV.size() == 0) fail(74'h0, actV);
      else cmpV(qV.pop_front(), qM.pop_front(), actV);
    end
    if (rst_n && replyStart) popR({1'b1, replyType, replyCount});
    if (rst_n && replyValid) popR({1'b0, replyName, 7'h0, replyEff});
  end

  // Waits for the host to return to idle.
  task waitIdle;
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (busy !== 1'b0 && k < 200);
    if (k >= 200) hang;
    repeat (8) @(posedge mclk);
  endtask

  // Sends one message with random id and flags; st is the verdict.
  task send(input logic [7:0] t, input logic [3:0] s, input logic [15:0] sr,
            input logic [15:0] ds, input logic [3:0] st);
    logic [11:0] i;
    logic [2:0] f;
    int k;
    i = 12'($random(seed));
    f = 3'($random(seed));
    ign = !(t == 8'h00 || t == 8'h01 || t == 8'h02 || t == 8'h08 ||
            t == 8'h0b);
    if (!ign) begin
      qV.push_back({st, 2'b00, f, t == 8'h00 && s == 4'h0, t, s, i, i[11:4],
                    sr, ds});
      qM.push_back(t == 8'h0b ? {1'b0, {73{1'b1}}} : {74{1'b1}});
    end
    @(posedge mclk);
    {ty, sub, src, dst, id} <= {t, s, sr, ds, i};
    {prio, trc, dfl} <= f;
    withData <= (pl.size() > 0);
    sendStart <= 1'b1;
    @(posedge mclk);
    sendStart <= 1'b0;
    for (int j = 0; j < pl.size(); j++) begin
      pV <= 1'b1;
      pW <= pl[j];
      pL <= (j == pl.size() - 1);
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (payloadReady !== 1'b1 && k < 100);
      if (k >= 100) hang;
    end
    pV <= 1'b0;
    pl = {};
    waitIdle;
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cmpB(1'b0, logicalStyle);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      {cfgWrite, cfgSlot, cfgAuth} <= {1'b1, 2'(k), k < 2};
      cfgName <= 16'(16'h0101 * (k + 1));
    end
    @(posedge mclk);
    cfgWrite <= 1'b0;
    nopBurst <= 1'b1;
    @(posedge mclk);
    nopBurst <= 1'b0;
    waitIdle;
    cmpB(1'b1, logicalStyle);
    send(8'h00, 4'h0, PORT, 16'h7777, 4'b1000);
    send(8'h00, 4'h3, PORT, 16'h7777, 4'b1000);
    send(8'h00, 4'h0, 16'h0101, 16'h7777, 4'b0100);
    pl = '{16'h0002, 16'h0101, 16'h0001, 16'h0303, 16'h0001};
    qR = '{{1'b1, 8'h03, 16'h0002}, {1'b0, 16'h0101, 8'h01},
           {1'b0, 16'h0303, 8'h00}};
    send(8'h03, 4'h0, PORT, 16'h0000, 4'b0000);
    send(8'h00, 4'h0, 16'h0101, 16'h7777, 4'b1000);
    send(8'h00, 4'h0, PORT, 16'h0202, 4'b0010);
    send(8'h01, 4'h0, PORT, 16'h7777, 4'b1000);
    send(8'h02, 4'h0, PORT, 16'h7777, 4'b1000);
    send(8'h08, 4'h0, PORT, 16'h7777, 4'b1000);
    send(8'h0b, 4'h0, PORT, 16'h0101, 4'b0001);
    qR = '{{1'b1, 8'h0c, 16'h0002}, {1'b0, 16'h0101, 8'h01},
           {1'b0, 16'h0202, 8'h00}};
    send(8'h0c, 4'h0, PORT, 16'h0000, 4'b0000);
    pl = '{16'h0000};
    qR = '{{1'b1, 8'h03, 16'h0000}};
    send(8'h03, 4'h0, PORT, 16'h0000, 4'b0000);
    send(8'h00, 4'h0, 16'h0101, 16'h7777, 4'b0100);
    cmpB(1'b1, qV.size() == 0 && qR.size() == 0);
    test_done;
  end
endmodule // host_leader_format_checker_tb_top
